// File: rtl/gpio_port_pkg.sv
package gpio_port_pkg;

    // ------------------------------------------------------------
    // Register word indices (byte address is four times the index).
    // ------------------------------------------------------------
    localparam logic [9:0] DATA_LAST = 10'h0FF;
    localparam logic [9:0] DIR_IDX = 10'h100;
    localparam logic [9:0] SENSE_IDX = 10'h101;
    localparam logic [9:0] DUAL_IDX = 10'h102;
    localparam logic [9:0] POL_IDX = 10'h103;
    localparam logic [9:0] UNMASK_IDX = 10'h104;
    localparam logic [9:0] RAW_IDX = 10'h105;
    localparam logic [9:0] MASKED_IDX = 10'h106;
    localparam logic [9:0] CLEAR_IDX = 10'h107;
    localparam logic [9:0] ALT_IDX = 10'h108;
    localparam logic [9:0] DRV_LOW_IDX = 10'h140;
    localparam logic [9:0] DRV_MID_IDX = 10'h141;
    localparam logic [9:0] DRV_HIGH_IDX = 10'h142;
    localparam logic [9:0] OPEN_DRAIN_IDX = 10'h143;
    localparam logic [9:0] PULL_UP_IDX = 10'h144;
    localparam logic [9:0] PULL_DOWN_IDX = 10'h145;
    localparam logic [9:0] SLEW_IDX = 10'h146;
    localparam logic [9:0] DIG_EN_IDX = 10'h147;
    localparam logic [9:0] LOCK_IDX = 10'h148;
    localparam logic [9:0] PERMIT_IDX = 10'h149;
    localparam logic [9:0] IDENT_FIRST = 10'h3F4;
    localparam logic [9:0] IDENT_LAST = 10'h3FF;

    // ------------------------------------------------------------
    // Reset values, keys and fixed read values.
    // ------------------------------------------------------------
    localparam logic [7:0] DRV_LOW_RESET = 8'hFF;
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551;
    localparam logic [31:0] LOCKED_READ = 32'h0000_0001;
    localparam logic [7:0] IDENT_BASE = 8'h5A;

    // Pad control bundle driven toward the pad ring.
    typedef struct packed {
        logic [7:0] drive_low_select;
        logic [7:0] drive_mid_select;
        logic [7:0] drive_high_select;
        logic [7:0] open_drain_select;
        logic [7:0] pull_up_select;
        logic [7:0] pull_down_select;
        logic [7:0] slew_select;
        logic [7:0] digital_input_enable;
    } pad_ctrl_type;

endpackage : gpio_port_pkg

// File: rtl/gpio_port_core.sv
// Operation
// RL1: direction 0 captures pin into data
// RL2: direction 1 drives data onto pin
// RL3: address bits 9:2 mask data access
// RL4: data register spans 256 word locations
// RL5: write updates only address-masked bits
// RL6: read returns zero for unmasked bits
// RL7: all pin causes form one interrupt
// RL8: edge flags latch until software clears
// RL9: level sources hold until recognized
// RL10: sense, dual edge, polarity select trigger
// RL11: sense 0 edge, polarity 1 high
// RL12: mask bit gates pin onto output
// RL13: raw flags show all pending pins
// RL14: masked flags show forwarded pins only
// RL15: unmasked port B bit four triggers converter
// RL16: writing one clears latched flag
// RL17: mask before changing trigger settings
// RL18: alternate function hands pin to peripheral
// RL19: port mode uses pin value register
// RL20: protected alternate bits need unlock, permit
// RL21: pad control bits per pin
// RL22: fixed identification registers
// RL23: reset leaves pins undriven except debug
// RL24: inputs synchronized before edge detection
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
module gpio_port_core #(
    parameter int WIDTH = 8,
    parameter logic [7:0] ALT_RESET = 8'h00,
    parameter logic [7:0] PERMIT_RESET = 8'hFF,
    parameter logic [7:0] IDENT_ID = 8'h00, // Arbitrary identification value.
    parameter bit IS_PORT_B = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Pins.
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out,
    output logic [WIDTH-1:0] pin_oe,
    // Alternate function peripherals.
    input wire logic [WIDTH-1:0] alt_out,
    input wire logic [WIDTH-1:0] alt_oe,
    output logic [WIDTH-1:0] alt_in,
    output logic [WIDTH-1:0] alt_function_select,
    // Pad control and events.
    output gpio_port_pkg::pad_ctrl_type pad_ctrl,
    output logic port_irq,
    output logic converter_trigger
);

    // ------------------------------------------------------------
    // Reset release and input synchronisers.
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q, rst_sync_d;
    logic rst_n;
    logic [WIDTH-1:0] meta_q, meta_d;
    logic [WIDTH-1:0] sync_q, sync_d;
    logic [WIDTH-1:0] prev_q, prev_d;

    // Reset leaves through two flops so every register quits reset on one edge.
    assign rst_sync_d = {rst_sync_q[0], 1'b1};

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= rst_sync_d;
        end
    end
    assign rst_n = rst_sync_q[1];

    // Two flops stand between the pins and all logic that reads them, and a
    // third keeps the previous sample for edge detection.
    always_comb begin
        meta_d = pin_in;
        sync_d = meta_q; // RL24
        prev_d = sync_q; // RL24
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // ------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------
    logic [WIDTH-1:0] data_q, data_d;
    logic [WIDTH-1:0] dir_q, dir_d;
    logic [WIDTH-1:0] sense_q, sense_d;
    logic [WIDTH-1:0] dual_q, dual_d;
    logic [WIDTH-1:0] pol_q, pol_d;
    logic [WIDTH-1:0] unmask_q, unmask_d;
    logic [WIDTH-1:0] edge_q, edge_d;
    logic [WIDTH-1:0] alt_q, alt_d;
    logic [WIDTH-1:0] permit_q, permit_d;
    logic unlocked_q, unlocked_d;
    gpio_port_pkg::pad_ctrl_type pad_q, pad_d;
    logic [31:0] rdata_q, rdata_d;
    logic trig_q, trig_d;

    logic [WIDTH-1:0] amask;
    logic [WIDTH-1:0] wbits;
    logic [WIDTH-1:0] edge_hit;
    logic [WIDTH-1:0] level_hit;
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] masked;
    logic [WIDTH-1:0] clr;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;
    logic data_hit;

    // The low address bits of a data access double as the per-bit mask.
    assign amask = reg_addr[WIDTH-1:0]; // RL3
    assign wbits = reg_wdata[WIDTH-1:0];
    assign data_hit = (reg_addr <= gpio_port_pkg::DATA_LAST); // RL4
    assign rise = sync_q & ~prev_q;
    assign fall = ~sync_q & prev_q;

    // ------------------------------------------------------------
    // Interrupt detection.
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            // Polarity 1 picks rising or high.
            if (dual_q[i]) begin // RL10
                edge_hit[i] = rise[i] | fall[i];
            end else if (pol_q[i]) begin // RL11
                edge_hit[i] = rise[i];
            end else begin
                edge_hit[i] = fall[i];
            end
            level_hit[i] = (sync_q[i] == pol_q[i]); // RL11
        end
    end

    assign clr = (reg_wr && reg_addr == gpio_port_pkg::CLEAR_IDX) ? wbits : '0; // RL16
    // Level pins follow the input; edge pins are sticky and a new edge beats a clear.
    assign raw = (sense_q & level_hit) | (~sense_q & edge_q); // RL13
    assign masked = raw & unmask_q; // RL14
    assign edge_d = edge_hit | (edge_q & ~clr); // RL8

    // ------------------------------------------------------------
    // Register writes and reads.
    // ------------------------------------------------------------
    always_comb begin
        data_d = data_q;
        dir_d = dir_q;
        sense_d = sense_q;
        dual_d = dual_q;
        pol_d = pol_q;
        unmask_d = unmask_q;
        alt_d = alt_q;
        permit_d = permit_q;
        unlocked_d = unlocked_q;
        pad_d = pad_q;
        // Input pins in port mode capture the sampled level.
        // A write to an input bit stands only until the next sample replaces it.
        for (int i = 0; i < WIDTH; i++) begin
            if (!dir_q[i]) begin // RL1
                data_d[i] = sync_q[i];
            end
        end
        if (reg_wr) begin
            if (data_hit) begin
                data_d = (data_d & ~amask) | (wbits & amask); // RL5
            end
            case (reg_addr)
                gpio_port_pkg::DIR_IDX: dir_d = wbits;
                gpio_port_pkg::SENSE_IDX: sense_d = wbits; // RL10
                gpio_port_pkg::DUAL_IDX: dual_d = wbits;
                gpio_port_pkg::POL_IDX: pol_d = wbits;
                gpio_port_pkg::UNMASK_IDX: unmask_d = wbits; // RL12
                gpio_port_pkg::ALT_IDX: begin
                    // Only permitted bits change, and only while unlocked.
                    for (int i = 0; i < WIDTH; i++) begin
                        if (permit_q[i] && unlocked_q) begin // RL20
                            alt_d[i] = wbits[i];
                        end
                    end
                end
                gpio_port_pkg::DRV_LOW_IDX: begin
                    pad_d.drive_low_select = wbits; // RL21
                end
                gpio_port_pkg::DRV_MID_IDX: pad_d.drive_mid_select = wbits;
                gpio_port_pkg::DRV_HIGH_IDX: pad_d.drive_high_select = wbits;
                gpio_port_pkg::OPEN_DRAIN_IDX: pad_d.open_drain_select = wbits;
                gpio_port_pkg::PULL_UP_IDX: pad_d.pull_up_select = wbits;
                gpio_port_pkg::PULL_DOWN_IDX: pad_d.pull_down_select = wbits;
                gpio_port_pkg::SLEW_IDX: pad_d.slew_select = wbits;
                gpio_port_pkg::DIG_EN_IDX: pad_d.digital_input_enable = wbits;
                gpio_port_pkg::LOCK_IDX: begin
                    // Any value other than the key locks again.
                    unlocked_d = (reg_wdata == gpio_port_pkg::UNLOCK_KEY);
                end
                gpio_port_pkg::PERMIT_IDX: begin
                    if (unlocked_q) begin
                        permit_d = wbits;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        // Read data are zero in every cycle that answers no read.
        rdata_d = '0;
        if (reg_rd) begin
            if (data_hit) begin
                rdata_d[WIDTH-1:0] = data_q & amask; // RL6
            end else if (reg_addr >= gpio_port_pkg::IDENT_FIRST) begin
                // Identification block: fixed bytes built from the id parameter.
                rdata_d[7:0] = gpio_port_pkg::IDENT_BASE ^ IDENT_ID ^ reg_addr[7:0]; // RL22
            end else begin
                case (reg_addr)
                    gpio_port_pkg::DIR_IDX: rdata_d[WIDTH-1:0] = dir_q;
                    gpio_port_pkg::SENSE_IDX: rdata_d[WIDTH-1:0] = sense_q;
                    gpio_port_pkg::DUAL_IDX: rdata_d[WIDTH-1:0] = dual_q;
                    gpio_port_pkg::POL_IDX: rdata_d[WIDTH-1:0] = pol_q;
                    gpio_port_pkg::UNMASK_IDX: rdata_d[WIDTH-1:0] = unmask_q;
                    gpio_port_pkg::RAW_IDX: rdata_d[WIDTH-1:0] = raw;
                    gpio_port_pkg::MASKED_IDX: rdata_d[WIDTH-1:0] = masked;
                    gpio_port_pkg::ALT_IDX: rdata_d[WIDTH-1:0] = alt_q;
                    gpio_port_pkg::DRV_LOW_IDX: rdata_d[7:0] = pad_q.drive_low_select;
                    gpio_port_pkg::DRV_MID_IDX: rdata_d[7:0] = pad_q.drive_mid_select;
                    gpio_port_pkg::DRV_HIGH_IDX: rdata_d[7:0] = pad_q.drive_high_select;
                    gpio_port_pkg::OPEN_DRAIN_IDX: rdata_d[7:0] = pad_q.open_drain_select;
                    gpio_port_pkg::PULL_UP_IDX: rdata_d[7:0] = pad_q.pull_up_select;
                    gpio_port_pkg::PULL_DOWN_IDX: rdata_d[7:0] = pad_q.pull_down_select;
                    gpio_port_pkg::SLEW_IDX: rdata_d[7:0] = pad_q.slew_select;
                    gpio_port_pkg::DIG_EN_IDX: rdata_d[7:0] = pad_q.digital_input_enable;
                    gpio_port_pkg::LOCK_IDX: begin
                        rdata_d = unlocked_q ? '0 : gpio_port_pkg::LOCKED_READ;
                    end
                    gpio_port_pkg::PERMIT_IDX: rdata_d[WIDTH-1:0] = permit_q;
                    default: rdata_d = '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Converter trigger.
    // ------------------------------------------------------------
    logic raw4_q, raw4_d;

    // Only a new unmasked event on port B bit four sends a pulse, so a flag
    // that is already pending when the mask opens sends none.
    always_comb begin
        raw4_d = raw[4];
        trig_d = IS_PORT_B && unmask_q[4] && !raw4_q && raw[4]; // RL15
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_q <= 1'b0;
            raw4_q <= 1'b0;
        end else begin
            trig_q <= trig_d;
            raw4_q <= raw4_d;
        end
    end

    // ------------------------------------------------------------
    // Port data and direction registers.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= '0;
            dir_q <= '0;
        end else begin
            data_q <= data_d;
            dir_q <= dir_d;
        end
    end

    // ------------------------------------------------------------
    // Interrupt settings and flags.
    // ------------------------------------------------------------
    // Edge flags latch in every sense mode, so software clears them before it
    // turns a pin to edge sense.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sense_q <= '0;
            dual_q <= '0;
            pol_q <= '0;
            unmask_q <= '0;
            edge_q <= '0;
        end else begin
            sense_q <= sense_d;
            dual_q <= dual_d;
            pol_q <= pol_d;
            unmask_q <= unmask_d;
            edge_q <= edge_d;
        end
    end

    // ------------------------------------------------------------
    // Alternate function, commit protection and pad control.
    // ------------------------------------------------------------
    // Debug pins leave reset with their peripheral, pull-up and input enabled.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alt_q <= ALT_RESET; // RL23
            permit_q <= PERMIT_RESET;
            unlocked_q <= 1'b0;
            pad_q <= '0;
            pad_q.drive_low_select <= gpio_port_pkg::DRV_LOW_RESET;
            pad_q.pull_up_select <= ALT_RESET; // RL23
            pad_q.digital_input_enable <= ALT_RESET; // RL23
        end else begin
            alt_q <= alt_d;
            permit_q <= permit_d;
            unlocked_q <= unlocked_d;
            pad_q <= pad_d;
        end
    end

    // ------------------------------------------------------------
    // Read data.
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (alt_q[i]) begin // RL18
                pin_out[i] = alt_out[i];
                pin_oe[i] = alt_oe[i];
            end else begin // RL19
                pin_out[i] = data_q[i]; // RL2
                pin_oe[i] = dir_q[i]; // RL2
            end
            // Open drain drives only low.
            if (pad_q.open_drain_select[i] && pin_out[i]) begin
                pin_oe[i] = 1'b0;
            end
        end
    end

    // Peripherals see the synchronised levels in every pin mode.
    assign alt_in = sync_q;
    assign alt_function_select = alt_q;
    assign pad_ctrl = pad_q;
    assign reg_rdata = rdata_q;
    assign port_irq = |masked; // RL7
    assign converter_trigger = trig_q;

endmodule : gpio_port_core

// File: sim/gpio_port_chk.sv
`timescale 1ns/10ps
module gpio_port_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire logic [9:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Pins, peripherals and events.
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] alt_out,
    input wire logic [7:0] alt_oe,
    input wire logic [7:0] alt_function_select,
    input wire gpio_port_pkg::pad_ctrl_type pad_ctrl,
    input wire logic port_irq,
    input wire logic converter_trigger
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h0000_0000) else $error("read data outside answer");
    a_read_mask: assert property (
        reg_rd && reg_addr[9:8] == 2'b00 |=>
        (reg_rdata & ~{24'h00_0000, $past(reg_addr[7:0])}) == 32'h0000_0000)
        else $error("masked data bit read nonzero");
    a_pin_capture: assert property (
        (pin_oe == 8'h00 && alt_function_select == 8'h00 && $stable(pin_in)) [*5] ##0
        (reg_rd && reg_addr == gpio_port_pkg::DATA_LAST) |=> reg_rdata[7:0] == $past(pin_in))
        else $error("input level not captured");
    a_data_drive: assert property (
        reg_wr && reg_addr == gpio_port_pkg::DATA_LAST && pin_oe == 8'hFF
        && alt_function_select == 8'h00 && pad_ctrl.open_drain_select == 8'h00
        |=> pin_out == $past(reg_wdata[7:0])) else $error("written data not on pins");
    a_irq_masked: assert property (
        reg_rd && reg_addr == gpio_port_pkg::MASKED_IDX |=> (reg_rdata != 32'h0000_0000)
        == $past(port_irq)) else $error("interrupt output disagrees with masked flags");
    a_alt_guard: assert property (
        $changed(alt_function_select) |-> $past(reg_wr && reg_addr == gpio_port_pkg::ALT_IDX))
        else $error("alternate select changed without a write");
    a_pad_guard: assert property (
        $changed(pad_ctrl) |-> $past(reg_wr && reg_addr[9:3] == 7'h28))
        else $error("pad control changed without a write");
    a_alt_pin: assert property (
        (((pin_oe ^ alt_oe) | (pin_out ^ alt_out)) & alt_function_select
        & ~pad_ctrl.open_drain_select) == 8'h00) else $error("peripheral not driving pin");
    a_trig_pulse: assert property (
        converter_trigger |-> (port_irq || $past(port_irq)) ##1 !converter_trigger)
        else $error("converter trigger pulse malformed");
endmodule : gpio_port_chk

bind gpio_port_core gpio_port_chk i_chk (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
    .alt_function_select(alt_function_select), .pad_ctrl(pad_ctrl), .port_irq(port_irq),
    .converter_trigger(converter_trigger));

// File: sim/gpio_pins_model.sv
`timescale 1ns/10ps
module gpio_pins_model (
    // Clock.
    input wire logic clk,
    // Port side.
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_in,
    // Peripheral side.
    output logic [7:0] alt_out,
    output logic [7:0] alt_oe,
    // Level held by the outside source.
    input wire logic [7:0] ext_val
);
    logic [7:0] pat_q = 8'h00;
    // A driven pin reads back its own level; otherwise the source holds it steady.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
    // The peripheral moves its output every cycle so a stale copy shows up.
    assign alt_oe = 8'hA5;
    assign alt_out = pat_q;
    always @(posedge clk) begin
        pat_q <= pat_q + 8'h01;
    end
endmodule : gpio_pins_model

// File: sim/gpio_port_core_tb.sv
`timescale 1ns/10ps
module gpio_port_core_tb;
    logic clk, arst_n, reg_wr, reg_rd, port_irq, converter_trigger;
    logic [9:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, seed, rv;
    logic [7:0] pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, alt_sel, ext_val, dat;
    gpio_port_pkg::pad_ctrl_type pad_ctrl;
    int miscompares, total_checks, cycles, pulses;
    logic [5:0] tbl [7] = '{6'h0B, 6'h05, 6'h13, 6'h2B, 6'h25, 6'h0D, 6'h0A};

    gpio_port_core #(.ALT_RESET(8'h80), .PERMIT_RESET(8'h7F), .IS_PORT_B(1'b1)) i_dut (
        .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
        .alt_in(alt_in), .alt_function_select(alt_sel), .pad_ctrl(pad_ctrl),
        .port_irq(port_irq), .converter_trigger(converter_trigger));
    gpio_pins_model i_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
        .alt_out(alt_out), .alt_oe(alt_oe), .ext_val(ext_val));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (converter_trigger === 1'b1) pulses <= pulses + 1;
        if (cycles == 6000) begin
            miscompares++;
            end_sim();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rchk(input string what, input logic [9:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(what, exp, reg_rdata);
    endtask : rchk

    // Fields of a case: sense, dual edge, polarity, start level, end level, unmask.
    task automatic irq_case(input logic [5:0] c);
        logic hit, hold;
        int n;
        hit = c[5] ? (c[1] == c[3]) : (c[2] != c[1]) && (c[4] || c[1] == c[3]);
        // An edge pin latches on the move away or on the move back.
        hold = c[5] ? (c[2] == c[3]) : (c[2] != c[1]);
        wr(gpio_port_pkg::UNMASK_IDX, 32'h0000_0000);
        ext_val[4] <= c[2];
        repeat (5) @(posedge clk);
        wr(gpio_port_pkg::SENSE_IDX, {27'h000_0000, c[5], 4'h0});
        wr(gpio_port_pkg::DUAL_IDX, {27'h000_0000, c[4], 4'h0});
        wr(gpio_port_pkg::POL_IDX, {27'h000_0000, c[3], 4'h0});
        wr(gpio_port_pkg::CLEAR_IDX, 32'h0000_00FF);
        wr(gpio_port_pkg::UNMASK_IDX, {27'h000_0000, c[0], 4'h0});
        n = pulses;
        ext_val[4] <= c[1];
        repeat (5) @(posedge clk);
        rchk("raw", gpio_port_pkg::RAW_IDX, {27'h000_0000, hit, 4'h0});
        rchk("masked", gpio_port_pkg::MASKED_IDX, {27'h000_0000, hit & c[0], 4'h0});
        chk("irq", {31'h0000_0000, hit & c[0]}, {31'h0000_0000, port_irq});
        chk("trigger", {31'h0000_0000, hit & c[0]}, {31'h0000_0000, pulses != n});
        @(posedge clk);
        ext_val[4] <= c[2];
        repeat (5) @(posedge clk);
        rchk("held", gpio_port_pkg::RAW_IDX, {27'h000_0000, hold, 4'h0});
        wr(gpio_port_pkg::CLEAR_IDX, 32'h0000_0010);
        rchk("cleared", gpio_port_pkg::RAW_IDX, {27'h000_0000, c[5] & hold, 4'h0});
    endtask : irq_case

    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ext_val} = '0;
        {miscompares, total_checks, cycles, pulses} = '0;
        seed = 32'h0000_5913;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("oe", 32'h0000_0080 & alt_oe, {24'h00_0000, pin_oe});
        rchk("lock", gpio_port_pkg::LOCK_IDX, gpio_port_pkg::LOCKED_READ);
        rchk("ident", gpio_port_pkg::IDENT_FIRST, {24'h00_0000, 8'h5A ^ 8'hF4});
        rchk("unmapped", 10'h1FF, 32'h0000_0000);
        for (int a = 'h140; a <= 'h147; a++) begin
            rv = rnd();
            dat = (a == 'h140) ? 8'hFF : ((a == 'h144 || a == 'h147) ? 8'h80 : 8'h00);
            rchk("pad reset", a[9:0], {24'h00_0000, dat});
            wr(a[9:0], rv);
            rchk("pad", a[9:0], {24'h00_0000, rv[7:0]});
        end
        chk("pad out", {24'h00_0000, rv[7:0]},
            {24'h00_0000, pad_ctrl.digital_input_enable});
        wr(gpio_port_pkg::OPEN_DRAIN_IDX, 32'h0000_0000);
        wr(gpio_port_pkg::ALT_IDX, 32'h0000_000F);
        rchk("alt locked", gpio_port_pkg::ALT_IDX, 32'h0000_0080);
        wr(gpio_port_pkg::LOCK_IDX, gpio_port_pkg::UNLOCK_KEY);
        wr(gpio_port_pkg::ALT_IDX, 32'h0000_000F);
        rchk("alt open", gpio_port_pkg::ALT_IDX, 32'h0000_008F);
        chk("alt port", 32'h0000_008F, {24'h00_0000, alt_sel});
        wr(gpio_port_pkg::PERMIT_IDX, 32'h0000_00FF);
        wr(gpio_port_pkg::ALT_IDX, 32'h0000_0000);
        wr(gpio_port_pkg::LOCK_IDX, 32'h0000_0000);
        rchk("alt off", gpio_port_pkg::ALT_IDX, 32'h0000_0000);
        wr(gpio_port_pkg::DIR_IDX, 32'h0000_00FF);
        wr(gpio_port_pkg::DATA_LAST, 32'h0000_005A);
        dat = 8'h5A;
        for (int k = 0; k < 26; k++) begin
            rv = (k == 0) ? 32'h0000_26EB : rnd();
            wr({2'b00, rv[15:8]}, rv);
            dat = (dat & ~rv[15:8]) | (rv[7:0] & rv[15:8]);
            rchk("data", {2'b00, rv[23:16]}, {24'h00_0000, dat & rv[23:16]});
            chk("pin_out", {24'h00_0000, dat}, {24'h00_0000, pin_out});
        end
        wr(gpio_port_pkg::DIR_IDX, 32'h0000_0000);
        rv = rnd();
        ext_val <= rv[7:0];
        repeat (5) @(posedge clk);
        rchk("capture", gpio_port_pkg::DATA_LAST, {24'h00_0000, rv[7:0]});
        chk("alt_in", {24'h00_0000, rv[7:0]}, {24'h00_0000, alt_in});
        foreach (tbl[i]) irq_case(tbl[i]);
        end_sim();
    end
endmodule : gpio_port_core_tb
